// ==== code_map_decode.sv ====
// program store region decode for the 4K code space
// assumes a 12-bit fetch address from the sequencer
`timescale 1ns/10ps
`include "core_regs_regs.svh"
module code_map_decode import core_regs_pkg::*; (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic [11:0] CODE_ADDR,
  output logic IS_VECTOR,
  output logic IS_USER,
  output logic IS_CONFIG
);
  // ----------------------------------------
  // region compare
  // ----------------------------------------
  assign IS_VECTOR = CODE_ADDR <= `CODE_VEC_END;
  assign IS_USER = CODE_ADDR >= `CODE_USER_LO && CODE_ADDR <= `CODE_USER_HI;
  assign IS_CONFIG = CODE_ADDR >= `CODE_CFG_LO;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  one_region_a: assert property ($onehot({IS_VECTOR, IS_USER, IS_CONFIG}))
    else $error("code address not in exactly one region");
endmodule

// ==== core_regs.sv ====
// core architectural registers, scratch RAM and data-space decode
// assumes the sequencer issues at most one access and one stack op a cycle
`timescale 1ns/10ps
`include "core_regs_regs.svh"
// Overview of operation
// - the arithmetic register is 8-bit read/write, clears at reset, feeds the ALU.
// - the operand register clears at reset, holds the MUL/DIV operand, else scratch.
// - the stack top resets to 07h and steps up on push, down on pop.
// - two 16-bit index pointers share 82h/83h, chosen by aux control bit 0.
// - ADD/ADDC/SUBB set carry, excess and half-carry; carry-only ops set carry.
// - MUL/DIV clear carry and set excess; SETB C sets and CLR C clears carry.
// - the flag word resets to zero with carry at bit 7 down to parity at bit 0.
// - bank select picks RAM 00h, 08h, 10h or 18h for the eight working registers.
// - the odd-ones flag is recomputed each cycle from the arithmetic register.
// - the code space is 000h-FFFh with vectors low and user code 060h-FFDh.
// - the config word sits at FFEh-FFFh and its low byte loads into F7h at power-up.
// - indirect reaches all 256 RAM bytes, direct only the lower 128.
// - RAM bytes 20h-2Fh are bit addressable.
// - special registers sit at 80h-FFh, those on 8-byte boundaries bit addressable.
// - there is no external data space.
// - the programmer uses five wires, or seven with P3.2/P3.5 driven by the device.
module core_regs import core_regs_pkg::*; #(
  parameter int RAM_DEPTH = 256
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire access_req_t REQ,
  output logic [7:0] RDATA,
  input wire alu_upd_t ALU,
  input wire logic STK_PUSH,
  input wire logic STK_POP,
  input wire logic [7:0] STK_WDATA,
  output logic [7:0] STK_RDATA,
  input wire logic PTR_LOAD,
  input wire logic PTR_INC,
  input wire logic [15:0] PTR_VAL,
  output logic [15:0] IDX_PTR,
  output logic [7:0] ACC_OUT,
  output logic [7:0] B_OUT,
  output logic [7:0] FLAGS_OUT,
  output logic [7:0] SP_OUT,
  output logic [7:4] AUX_OUT,
  input wire logic CFG_LOAD,
  input wire logic [15:0] CFG_WORD,
  output logic [7:0] CFG_LOW_OUT,
  output logic [7:0] CFG_HIGH_OUT,
  input wire logic [11:0] CODE_ADDR,
  output logic CODE_VECTOR,
  output logic CODE_USER,
  output logic CODE_CONFIG,
  input wire icp_mode_t ICP_MODE,
  input wire logic [3:0] ICP_PIN_IN,
  output logic [3:0] ICP_PIN_SYNC,
  input wire logic [1:0] ICP_DRV,
  output logic [1:0] ICP_PIN_OUT,
  output logic [1:0] ICP_PIN_OE
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [7:0] ram [RAM_DEPTH];
  logic [7:0] acc_reg, acc_next;
  logic [7:0] b_reg, b_next;
  logic [7:0] sp_reg, sp_next;
  logic [7:1] fw_reg, fw_next;
  logic [7:0] aux_reg, aux_next;
  logic [7:0] plo_reg [2];
  logic [7:0] phi_reg [2];
  logic [7:0] cfgl_reg, cfgh_reg;
  logic [7:0] rdata_reg, stk_reg;
  logic [1:0] drv_reg;

  // ----------------------------------------
  // address resolution
  // ----------------------------------------
  wire is_dir = REQ.mode == AM_DIRECT;
  wire is_ind = REQ.mode == AM_INDIRECT;
  wire is_bit = REQ.mode == AM_BIT;
  wire is_wr = REQ.mode == AM_WORKREG;
  wire is_xd = REQ.mode == AM_XDATA;
  wire [1:0] bank = fw_reg[`FW_BANK_HI:`FW_BANK_LO];
  wire [7:0] bit_byte = REQ.addr[7] ? {REQ.addr[7:3], 3'h0}
                                    : `BITRAM_BASE + {4'h0, REQ.addr[6:3]};
  wire [2:0] bit_pos = REQ.addr[2:0];
  // direct space above 7Fh is the special registers, never RAM
  wire to_sfr = (is_dir && REQ.addr[7]) || (is_bit && REQ.addr[7]);
  wire to_ram = REQ.en && !is_xd && !to_sfr;
  wire [7:0] wr_idx = {3'h0, bank, REQ.addr[2:0]};
  wire [7:0] ram_idx = is_bit ? bit_byte : (is_wr ? wr_idx : REQ.addr);
  wire [7:0] sfr_adr = is_bit ? bit_byte : REQ.addr;
  wire sel = aux_reg[`AUX_CHOICE];
  wire parity = ^acc_reg;
  wire [7:0] fw_full = {fw_reg, parity};

  // ----------------------------------------
  // special register read mux
  // ----------------------------------------
  logic [7:0] sfr_rd;
  always_comb begin
    case (sfr_adr)
      `SFR_STACK_TOP: sfr_rd = sp_reg;
      `SFR_IDX_LOW: sfr_rd = plo_reg[sel];
      `SFR_IDX_HIGH: sfr_rd = phi_reg[sel];
      `SFR_FLAG_WORD: sfr_rd = fw_full;
      `SFR_ARITH: sfr_rd = acc_reg;
      `SFR_OPERAND: sfr_rd = b_reg;
      `SFR_CFG_LOW: sfr_rd = cfgl_reg;
      `SFR_AUX_CTRL: sfr_rd = {aux_reg[7:4], 3'h0, aux_reg[0]};
      default: sfr_rd = `RST_ZERO;
    endcase
  end

  // byte under access, then bit merge for bit writes
  wire [7:0] cur_byte = to_sfr ? sfr_rd : ram[ram_idx];
  logic [7:0] bit_merged;
  always_comb begin
    bit_merged = cur_byte;
    bit_merged[bit_pos] = REQ.wdata[0];
  end
  wire [7:0] wval = is_bit ? bit_merged : REQ.wdata;
  wire [7:0] rd_val = is_xd ? `RST_ZERO
                    : is_bit ? {7'h0, cur_byte[bit_pos]} : cur_byte;

  // write strobes per special register
  wire sfr_we = REQ.en && REQ.wr && to_sfr;
  wire we_sp = sfr_we && sfr_adr == `SFR_STACK_TOP;
  wire we_lo = sfr_we && sfr_adr == `SFR_IDX_LOW;
  wire we_hi = sfr_we && sfr_adr == `SFR_IDX_HIGH;
  wire we_fw = sfr_we && sfr_adr == `SFR_FLAG_WORD;
  wire we_acc = sfr_we && sfr_adr == `SFR_ARITH;
  wire we_b = sfr_we && sfr_adr == `SFR_OPERAND;
  wire we_cfg = sfr_we && sfr_adr == `SFR_CFG_LOW;
  wire we_aux = sfr_we && sfr_adr == `SFR_AUX_CTRL;

  // ----------------------------------------
  // next-state for the core registers
  // ----------------------------------------
  assign acc_next = ALU.acc_we ? ALU.acc : (we_acc ? wval : acc_reg);
  assign b_next = ALU.b_we ? ALU.b : (we_b ? wval : b_reg);
  // stack ops win over a software write of the pointer
  assign sp_next = STK_PUSH ? sp_reg + 8'h01
                 : STK_POP ? sp_reg - 8'h01
                 : we_sp ? wval : sp_reg;
  // aux bit 7 is a strobe that clears itself a cycle later
  assign aux_next = we_aux ? {wval[7:4], 3'h0, wval[0]}
                  : {1'b0, aux_reg[6:0]};

  // flag word: a software write first, the datapath result on top
  always_comb begin
    fw_next = we_fw ? wval[7:1] : fw_reg;
    case (ALU.cls)
      FC_ARITH: begin
        fw_next[`FW_CARRY] = ALU.cy;
        fw_next[`FW_HALF] = ALU.ac;
        fw_next[`FW_EXCESS] = ALU.ov;
      end
      FC_MULDIV: begin
        fw_next[`FW_CARRY] = 1'b0;
        fw_next[`FW_EXCESS] = ALU.ov;
      end
      FC_CARRY: fw_next[`FW_CARRY] = ALU.cy;
      FC_SETC: fw_next[`FW_CARRY] = 1'b1;
      FC_CLRC: fw_next[`FW_CARRY] = 1'b0;
      default: fw_next = fw_next;
    endcase
  end

  // ----------------------------------------
  // core register flops
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      acc_reg <= `RST_ZERO;
      b_reg <= `RST_ZERO;
      sp_reg <= `RST_STACK_TOP;
      fw_reg <= 7'h00;
      aux_reg <= `RST_ZERO;
    end else begin
      acc_reg <= acc_next;
      b_reg <= b_next;
      sp_reg <= sp_next;
      fw_reg <= fw_next;
      aux_reg <= aux_next;
    end
  end

  // ----------------------------------------
  // dual index pointers, one per choice
  // ----------------------------------------
  for (genvar p = 0; p < 2; p++) begin : g_ptr
    wire mine = sel == 1'(p);
    wire [15:0] cur = {phi_reg[p], plo_reg[p]};
    wire [15:0] inc = cur + 16'h0001;
    always_ff @(posedge CLK) begin
      if (!RESET_N) begin
        plo_reg[p] <= `RST_ZERO;
        phi_reg[p] <= `RST_ZERO;
      end else if (mine && PTR_LOAD) begin
        {phi_reg[p], plo_reg[p]} <= PTR_VAL;
      end else if (mine && PTR_INC) begin
        {phi_reg[p], plo_reg[p]} <= inc;
      end else if (mine) begin
        if (we_lo) plo_reg[p] <= wval;
        if (we_hi) phi_reg[p] <= wval;
      end
    end
  end

  // ----------------------------------------
  // scratch RAM, one write port
  // ----------------------------------------
  // a push and an access write never share a cycle; push has priority
  wire ram_we = STK_PUSH || (to_ram && REQ.wr);
  wire [7:0] ram_widx = STK_PUSH ? sp_reg + 8'h01 : ram_idx;
  wire [7:0] ram_wval = STK_PUSH ? STK_WDATA : wval;
  always_ff @(posedge CLK) begin
    if (ram_we) begin
      ram[ram_widx] <= ram_wval;
    end
  end

  // ----------------------------------------
  // read data, pop data and config word
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      rdata_reg <= `RST_ZERO;
      stk_reg <= `RST_ZERO;
    end else begin
      if (REQ.en && !REQ.wr) rdata_reg <= rd_val;
      if (STK_POP) stk_reg <= ram[sp_reg];
    end
  end

  // loaded by the power-up strobe or a write to F7h, never by reset, so later resets keep it
  always_ff @(posedge CLK) begin
    if (CFG_LOAD) begin
      cfgl_reg <= CFG_WORD[7:0];
      cfgh_reg <= CFG_WORD[15:8];
    end else if (we_cfg) begin
      cfgl_reg <= wval;
    end
  end

  // ----------------------------------------
  // programming pins
  // ----------------------------------------
  // three-stage sync; the filtered level moves once stages 2 and 3 agree
  logic [3:0] s1, s2, s3, filt;
  for (genvar k = 0; k < 4; k++) begin : g_sync
    always_ff @(posedge CLK) begin
      if (!RESET_N) begin
        s1[k] <= 1'b0;
        s2[k] <= 1'b0;
        s3[k] <= 1'b0;
        filt[k] <= 1'b0;
      end else begin
        s1[k] <= ICP_PIN_IN[k];
        s2[k] <= s1[k];
        s3[k] <= s2[k];
        if (s2[k] == s3[k]) filt[k] <= s3[k];
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) drv_reg <= 2'h0;
    else drv_reg <= ICP_DRV;
  end

  wire wide = ICP_MODE == ICP_7W;
  wire on = ICP_MODE != ICP_OFF;
  // extra wires only count in the seven-wire form
  assign ICP_PIN_SYNC = {filt[3:2] & {2{wide}}, filt[1:0] & {2{on}}};
  assign ICP_PIN_OE = {2{wide}};
  assign ICP_PIN_OUT = drv_reg & {2{wide}};

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign RDATA = rdata_reg;
  assign STK_RDATA = stk_reg;
  assign IDX_PTR = {phi_reg[sel], plo_reg[sel]};
  assign ACC_OUT = acc_reg;
  assign B_OUT = b_reg;
  assign FLAGS_OUT = fw_full;
  assign SP_OUT = sp_reg;
  assign AUX_OUT = aux_reg[7:4];
  assign CFG_LOW_OUT = cfgl_reg;
  assign CFG_HIGH_OUT = cfgh_reg;

  code_map_decode u_map (
    .CLK(CLK),
    .RESET_N(RESET_N),
    .CODE_ADDR(CODE_ADDR),
    .IS_VECTOR(CODE_VECTOR),
    .IS_USER(CODE_USER),
    .IS_CONFIG(CODE_CONFIG)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  // expected working register, indexed from the exported bank bits, not the decode
  wire [7:0] exp_wr = ram[{3'h0, FLAGS_OUT[4:3], REQ.addr[2:0]}];

  acc_reset_zero_a: assert property (disable iff (1'b0) !RESET_N |=> ACC_OUT == 8'h00)
    else $error("arith register not zero after reset");
  b_reset_zero_a: assert property (disable iff (1'b0) !RESET_N |=> B_OUT == 8'h00)
    else $error("operand register not zero after reset");
  sp_reset_a: assert property (disable iff (1'b0) !RESET_N |=> SP_OUT == 8'h07)
    else $error("stack top not 07h after reset");
  push_order_a: assert property (STK_PUSH |=> SP_OUT == $past(SP_OUT) + 8'h01
      && ram[SP_OUT] == $past(STK_WDATA))
    else $error("push did not pre-increment");
  ptr_choice_a: assert property (we_lo && !PTR_LOAD && !PTR_INC
      |=> plo_reg[$past(sel)] == $past(wval))
    else $error("index low write missed chosen pointer");
  arith_flags_a: assert property (ALU.cls == FC_ARITH
      |=> FLAGS_OUT[7:6] == $past({ALU.cy, ALU.ac}) && FLAGS_OUT[2] == $past(ALU.ov))
    else $error("arith flags wrong");
  muldiv_flags_a: assert property (ALU.cls == FC_MULDIV
      |=> !FLAGS_OUT[7] && FLAGS_OUT[2] == $past(ALU.ov))
    else $error("mul/div flags wrong");
  parity_a: assert property (FLAGS_OUT[0] == ^ACC_OUT)
    else $error("odd-ones flag stale");
  bank_read_a: assert property (REQ.en && !REQ.wr && is_wr && !ram_we
      |=> RDATA == $past(exp_wr))
    else $error("working register read from wrong bank");
  direct_high_a: assert property (REQ.en && is_dir && REQ.addr[7] |-> !to_ram)
    else $error("direct high address reached RAM");
  no_xdata_a: assert property (REQ.en && !REQ.wr && is_xd |=> RDATA == 8'h00)
    else $error("external data read not zero");
  icp_oe_a: assert property (ICP_MODE != ICP_7W |-> ICP_PIN_OE == 2'h0)
    else $error("pins driven outside seven-wire form");

  push_pop_c: cover property (STK_PUSH ##1 STK_POP);
  bit_write_c: cover property (REQ.en && REQ.wr && is_bit && !REQ.addr[7]);
  icp_wide_c: cover property (ICP_MODE == ICP_7W);
  ptr_swap_c: cover property (we_aux ##1 PTR_INC);
endmodule

// ==== core_regs_pkg.sv ====
// types shared by the core register block
// assumes core_regs_regs.svh sits in the same folder
package core_regs_pkg;

  // ----------------------------------------
  // data space access
  // ----------------------------------------
  typedef enum logic [4:0] {
    AM_DIRECT = 5'b00001,
    AM_INDIRECT = 5'b00010,
    AM_BIT = 5'b00100,
    AM_WORKREG = 5'b01000,
    AM_XDATA = 5'b10000
  } acc_mode_t;

  typedef struct packed {
    logic en;
    logic wr;
    acc_mode_t mode;
    logic [7:0] addr;
    logic [7:0] wdata;
  } access_req_t;

  // ----------------------------------------
  // flag updates from the datapath and programming pin modes
  // ----------------------------------------
  typedef enum logic [5:0] {
    FC_NONE = 6'b000001,
    FC_ARITH = 6'b000010,
    FC_MULDIV = 6'b000100,
    FC_CARRY = 6'b001000,
    FC_SETC = 6'b010000,
    FC_CLRC = 6'b100000
  } flag_class_t;

  typedef struct packed {
    flag_class_t cls;
    logic cy;
    logic ov;
    logic ac;
    logic acc_we;
    logic [7:0] acc;
    logic b_we;
    logic [7:0] b;
  } alu_upd_t;

  typedef enum logic [2:0] {
    ICP_OFF = 3'b001,
    ICP_5W = 3'b010,
    ICP_7W = 3'b100
  } icp_mode_t;
endpackage

// ==== core_regs_regs.svh ====
// offsets, field positions, reset values and map bounds
// assumes inclusion by the design modules; the package does not include it
`ifndef CORE_REGS_REGS_SVH
`define CORE_REGS_REGS_SVH

// ----------------------------------------
// special register offsets
// ----------------------------------------
`define SFR_STACK_TOP 8'h81
`define SFR_IDX_LOW 8'h82
`define SFR_IDX_HIGH 8'h83
`define SFR_FLAG_WORD 8'hd0
`define SFR_ARITH 8'he0
`define SFR_OPERAND 8'hf0
`define SFR_CFG_LOW 8'hf7
`define SFR_AUX_CTRL 8'hf8

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_STACK_TOP 8'h07
`define RST_ZERO 8'h00

// ----------------------------------------
// flag word and aux control fields
// ----------------------------------------
`define FW_CARRY 7
`define FW_HALF 6
`define FW_BANK_HI 4
`define FW_BANK_LO 3
`define FW_EXCESS 2
`define AUX_CHOICE 0
`define AUX_SELFCLR 7

// ----------------------------------------
// data and program space bounds
// ----------------------------------------
`define BITRAM_BASE 8'h20
`define SFR_BASE 8'h80
`define CODE_VEC_END 12'h05f
`define CODE_USER_LO 12'h060
`define CODE_USER_HI 12'hffd
`define CODE_CFG_LO 12'hffe
`endif

// ==== tb_top.sv ====
// self-checking bench for the core register block, one task per scenario
// assumes core_regs_pkg, core_regs_regs.svh and the design files compile first
`timescale 1ns/10ps
module tb_top import core_regs_pkg::*; ;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  access_req_t req = '0;
  alu_upd_t alu_idle = '{cls: FC_NONE, default: '0};
  alu_upd_t alu = '{cls: FC_NONE, default: '0};
  logic stk_push = 1'b0, stk_pop = 1'b0, ptr_load = 1'b0, ptr_inc = 1'b0, cfg_load = 1'b0;
  logic [7:0] stk_wdata = 8'h00;
  logic [15:0] ptr_val = 16'h0000, cfg_word = 16'h0000;
  logic [11:0] code_addr = 12'h000;
  icp_mode_t icp_mode = ICP_OFF;
  logic [3:0] icp_pin_in = 4'h0;
  logic [1:0] icp_drv = 2'b00;
  logic [7:0] rdata, stk_rdata, acc_out, b_out, flags_out, sp_out, cfg_low, cfg_high;
  logic [15:0] idx_ptr;
  logic [7:4] aux_out;
  logic [3:0] icp_sync;
  logic [1:0] icp_out, icp_oe;
  logic c_vec, c_user, c_cfg;
  int num_errors = 0;
  int samples_checked = 0;

  // ----------------------------------------
  // clock and device
  // ----------------------------------------
  // 40 MHz system clock
  always #12.5 clk = ~clk;

  core_regs u_core_regs (.CLK(clk), .RESET_N(rst_n), .REQ(req), .RDATA(rdata), .ALU(alu),
    .STK_PUSH(stk_push), .STK_POP(stk_pop), .STK_WDATA(stk_wdata), .STK_RDATA(stk_rdata),
    .PTR_LOAD(ptr_load), .PTR_INC(ptr_inc), .PTR_VAL(ptr_val), .IDX_PTR(idx_ptr),
    .ACC_OUT(acc_out), .B_OUT(b_out), .FLAGS_OUT(flags_out), .SP_OUT(sp_out),
    .AUX_OUT(aux_out), .CFG_LOAD(cfg_load), .CFG_WORD(cfg_word), .CFG_LOW_OUT(cfg_low),
    .CFG_HIGH_OUT(cfg_high), .CODE_ADDR(code_addr), .CODE_VECTOR(c_vec), .CODE_USER(c_user),
    .CODE_CONFIG(c_cfg), .ICP_MODE(icp_mode), .ICP_PIN_IN(icp_pin_in),
    .ICP_PIN_SYNC(icp_sync), .ICP_DRV(icp_drv), .ICP_PIN_OUT(icp_out), .ICP_PIN_OE(icp_oe));

  // ----------------------------------------
  // compare, access and closing tasks
  // ----------------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // one access, then an idle cycle so en is never driven twice in one step
  task automatic acc(input logic w, input acc_mode_t m, input logic [7:0] a, input logic [7:0] d);
    req <= '{en: 1'b1, wr: w, mode: m, addr: a, wdata: d};
    @(negedge clk);
    req.en <= 1'b0;
    @(negedge clk);
  endtask

  task automatic rd(input acc_mode_t m, input logic [7:0] a, input logic [7:0] exp, string what);
    acc(1'b0, m, a, 8'h00);
    chk8(rdata, exp, what);
  endtask

  task automatic end_of_test();
    $display("errors %0d, comparisons %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // mid-run reset also proves the config low byte survives a non power-up reset
  task automatic t_reset(input logic [7:0] cfg_exp);
    rst_n <= 1'b0;
    repeat (2) @(negedge clk);
    rst_n <= 1'b1;
    chk8(acc_out, 8'h00, "acc reset");
    chk8(b_out, 8'h00, "b reset");
    chk8(sp_out, 8'h07, "sp reset");
    chk8(flags_out, 8'h00, "flags reset");
    chk16(idx_ptr, 16'h0000, "ptr reset");
    chk8(cfg_low, cfg_exp, "cfg kept");
  endtask

  task automatic t_config();
    cfg_word <= 16'ha5c3;
    cfg_load <= 1'b1;
    @(negedge clk);
    cfg_load <= 1'b0;
    chk16({cfg_high, cfg_low}, 16'ha5c3, "cfg load");
    rd(AM_DIRECT, 8'hf7, 8'hc3, "cfg sfr");
    acc(1'b1, AM_DIRECT, 8'hf7, 8'h12);
    chk16({cfg_high, cfg_low}, 16'ha512, "cfg rewrite");
  endtask

  task automatic t_flags();
    flag_class_t cl[7] = '{FC_ARITH, FC_CARRY, FC_MULDIV, FC_SETC, FC_CLRC, FC_MULDIV, FC_NONE};
    logic [2:0] fin[7] = '{3'b111, 3'b000, 3'b100, 3'b000, 3'b111, 3'b110, 3'b100};
    logic [7:0] ex[7] = '{8'hc4, 8'h44, 8'h40, 8'hc0, 8'h40, 8'h44, 8'h44};
    // fin is carry, excess, half-carry offered by the datapath
    for (int i = 0; i < 7; i++) begin
      alu <= '{cls: cl[i], cy: fin[i][2], ov: fin[i][1], ac: fin[i][0], default: '0};
      @(negedge clk);
      chk8(flags_out, ex[i], "flag class");
    end
    alu <= alu_idle;
    acc(1'b1, AM_DIRECT, 8'hd0, 8'hff);
    rd(AM_DIRECT, 8'hd0, 8'hfe, "flag word rw");
    acc(1'b1, AM_BIT, 8'hd7, 8'h00);
    chk8(flags_out, 8'h7e, "carry bit write");
  endtask

  task automatic t_acc_b();
    logic [7:0] v[5] = '{8'h01, 8'h03, 8'h80, 8'h7f, 8'h00};
    foreach (v[i]) begin
      alu <= '{cls: FC_NONE, acc_we: 1'b1, acc: v[i], b_we: 1'b1, b: ~v[i], default: '0};
      @(negedge clk);
      chk16({acc_out, b_out}, {v[i], ~v[i]}, "alu load");
      chk8({7'h00, flags_out[0]}, {7'h00, ^v[i]}, "parity");
    end
    alu <= alu_idle;
    acc(1'b1, AM_DIRECT, 8'he0, 8'hc1);
    rd(AM_DIRECT, 8'he0, 8'hc1, "acc sfr");
    chk8({7'h00, flags_out[0]}, 8'h01, "parity sfr");
    acc(1'b1, AM_DIRECT, 8'hf0, 8'h3c);
    acc(1'b1, AM_BIT, 8'hf0, 8'h01);
    rd(AM_DIRECT, 8'hf0, 8'h3d, "b bit");
    acc(1'b1, AM_BIT, 8'he3, 8'h01);
    chk8(acc_out, 8'hc9, "acc bit");
  endtask

  task automatic t_stack();
    stk_push <= 1'b1;
    stk_wdata <= 8'h55;
    @(negedge clk);
    stk_wdata <= 8'haa;
    @(negedge clk);
    stk_push <= 1'b0;
    chk8(sp_out, 8'h09, "sp after push");
    rd(AM_INDIRECT, 8'h08, 8'h55, "first push slot");
    rd(AM_INDIRECT, 8'h09, 8'haa, "second push slot");
    stk_pop <= 1'b1;
    @(negedge clk);
    chk16({stk_rdata, sp_out}, 16'haa08, "pop one");
    @(negedge clk);
    stk_pop <= 1'b0;
    chk16({stk_rdata, sp_out}, 16'h5507, "pop two");
  endtask

  task automatic t_pointers();
    acc(1'b1, AM_DIRECT, 8'hf8, 8'hff);
    chk8({4'h0, aux_out}, 8'h07, "aux strobe cleared");
    acc(1'b1, AM_DIRECT, 8'h82, 8'h12);
    acc(1'b1, AM_DIRECT, 8'h83, 8'h34);
    chk16(idx_ptr, 16'h3412, "pointer one");
    rd(AM_DIRECT, 8'hf8, 8'h71, "aux readback");
    acc(1'b1, AM_DIRECT, 8'hf8, 8'h00);
    chk16(idx_ptr, 16'h0000, "pointer zero kept");
    ptr_val <= 16'hbeff;
    ptr_load <= 1'b1;
    @(negedge clk);
    ptr_load <= 1'b0;
    ptr_inc <= 1'b1;
    @(negedge clk);
    ptr_inc <= 1'b0;
    chk16(idx_ptr, 16'hbf00, "load then step");
    acc(1'b1, AM_BIT, 8'hf8, 8'h01);
    rd(AM_DIRECT, 8'h82, 8'h12, "choice by bit");
  endtask

  task automatic t_data_space();
    for (int k = 0; k < 4; k++) begin
      acc(1'b1, AM_DIRECT, 8'hd0, 8'(k << 3));
      acc(1'b1, AM_WORKREG, 8'h05, 8'(8'h60 + k));
      rd(AM_INDIRECT, 8'(k * 8 + 5), 8'(8'h60 + k), "bank map");
      rd(AM_WORKREG, 8'h05, 8'(8'h60 + k), "bank read");
    end
    acc(1'b1, AM_INDIRECT, 8'h90, 8'h5a);
    rd(AM_INDIRECT, 8'h90, 8'h5a, "upper ram");
    rd(AM_DIRECT, 8'h90, 8'h00, "direct upper");
    acc(1'b1, AM_DIRECT, 8'h40, 8'h33);
    rd(AM_INDIRECT, 8'h40, 8'h33, "lower ram");
    acc(1'b1, AM_DIRECT, 8'h21, 8'h00);
    acc(1'b1, AM_BIT, 8'h0a, 8'h01);
    rd(AM_DIRECT, 8'h21, 8'h04, "ram bit");
    acc(1'b1, AM_BIT, 8'h7f, 8'h01);
    rd(AM_BIT, 8'h7f, 8'h01, "last ram bit");
    acc(1'b1, AM_XDATA, 8'h40, 8'hee);
    rd(AM_XDATA, 8'h40, 8'h00, "no external");
    rd(AM_INDIRECT, 8'h40, 8'h33, "ram untouched");
  endtask

  task automatic t_code_map();
    logic [11:0] a[6] = '{12'h000, 12'h05f, 12'h060, 12'hffd, 12'hffe, 12'hfff};
    logic [7:0] ex[6] = '{8'h04, 8'h04, 8'h02, 8'h02, 8'h01, 8'h01};
    foreach (a[i]) begin
      code_addr <= a[i];
      @(negedge clk);
      chk8({5'h00, c_vec, c_user, c_cfg}, ex[i], "code region");
    end
  endtask

  task automatic t_icp();
    icp_mode_t m[3] = '{ICP_7W, ICP_5W, ICP_OFF};
    logic [7:0] ex[3] = '{8'heb, 8'h03, 8'h00};
    icp_pin_in <= 4'hb;
    icp_drv <= 2'b10;
    // ex packs oe, driven pins, then synchronised inputs
    foreach (m[i]) begin
      icp_mode <= m[i];
      repeat (6) @(negedge clk);
      chk8({icp_oe, icp_out, icp_sync}, ex[i], "icp pins");
    end
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  // tests need well under 1000 cycles, so this span only trips on a hang
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    $display("BAD %0t watchdog expired", $time);
    end_of_test();
  end

  initial begin
    repeat (2) @(negedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    t_config();
    t_reset(8'h12);
    t_flags();
    t_acc_b();
    t_stack();
    t_pointers();
    t_data_space();
    t_code_map();
    t_icp();
    end_of_test();
  end
endmodule
